//--- core/strobe_map.svh
`ifndef STROBE_MAP_SVH
`define STROBE_MAP_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_ONE_SHOT_DELAY 8'h04
`define REG_ONE_SHOT_WIDTH 8'h08
`define REG_PERIOD 8'h0c
`define REG_ACQ_DELAY 8'h10
`define REG_INTEG 8'h14
`define REG_STATUS 8'h18
`define REG_ELAPSED 8'h1c

// control field positions
`define CTRL_ONE_SHOT_EN 0
`define CTRL_PERIODIC_EN 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 3
`define CTRL_SOFT_TRIG 4

// status field positions
`define STAT_CYCLE 0
`define STAT_INTEG 1
`define STAT_ONE_SHOT 2
`define STAT_PERIODIC 3

// reset values
`define RST_CTRL 32'h0000_0000
`define RST_TIME 24'h00_0000

// timing
`define CLK_PERIOD_NS 10
`define HALF_US_NS 500
`define HALF_US_CYCLES (`HALF_US_NS / `CLK_PERIOD_NS)

`endif

//--- core/strobe_pkg.sv
package strobe_pkg;
	typedef enum logic [1:0] {
		MODE_SOFTWARE,
		MODE_EDGE,
		MODE_LEVEL,
		MODE_SPARE
	} trig_mode_e;
endpackage

//--- core/strobe_if.sv
interface strobe_if #(
	parameter int TIME_W = 24
);
	logic clear;
	logic half_tick;
	logic us_tick;
	logic start;
	logic integrating;
	logic enable;
	logic level_mode;
	logic wave;
	logic [TIME_W-1:0] period;
	logic [TIME_W:0] remaining;

	modport timebase (
		input clear,
		output half_tick,
		output us_tick
	);
	modport wave_gen (
		input half_tick,
		input us_tick,
		input start,
		input integrating,
		input enable,
		input level_mode,
		input period,
		input remaining,
		output wave
	);
	modport ctrl (
		output clear,
		output start,
		output integrating,
		output enable,
		output level_mode,
		output period,
		output remaining,
		input half_tick,
		input us_tick,
		input wave
	);
endinterface

//--- core/us_tick_gen.sv
`include "strobe_map.svh"

module us_tick_gen
	import strobe_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	strobe_if.timebase tb
);
	localparam logic [6:0] LAST = 7'(`HALF_US_CYCLES - 1);

	logic [6:0] cnt_q;
	logic odd_q;

	// clear realigns the time base to the trigger
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 7'h00;
		end else if (tb.clear || cnt_q == LAST) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			odd_q <= 1'b0;
		end else if (tb.clear) begin
			odd_q <= 1'b0;
		end else if (cnt_q == LAST) begin
			odd_q <= ~odd_q;
		end
	end

	assign tb.half_tick = !tb.clear && cnt_q == LAST;
	assign tb.us_tick = tb.half_tick && odd_q;
endmodule

//--- core/periodic_strobe.sv
module periodic_strobe
	import strobe_pkg::*;
#(
	parameter int TIME_W = 24
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	strobe_if.wave_gen ws
);
	logic run_q;
	logic tick_q;
	logic [TIME_W:0] phase_q;
	logic [TIME_W:0] half_len;
	logic [TIME_W:0] last_phase;
	logic fits_start;
	logic at_last;

	// start trails the us tick by a clock, so the tick trails too; else the first half is short
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= ws.half_tick;
		end
	end

	// phase counts half microseconds, so odd periods stay exactly 50%
	assign half_len = {1'b0, ws.period};
	assign last_phase = {ws.period, 1'b0} - {{TIME_W{1'b0}}, 1'b1};
	assign at_last = tick_q && phase_q == last_phase;
	// outside level mode, a period starts only if it ends before integration does
	assign fits_start = ws.remaining > half_len;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_q <= 1'b0;
		end else if (!ws.integrating) begin
			run_q <= 1'b0;
		end else if (ws.start) begin
			// zero, or outside level mode too long, a period leaves it idle
			run_q <= ws.enable && ws.period != '0 && (ws.level_mode || fits_start);
		end else if (at_last && run_q) begin
			// tail gap stays within one period
			run_q <= ws.level_mode || fits_start;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_q <= '0;
		end else if (!ws.integrating || ws.start || at_last) begin
			phase_q <= '0;
		end else if (tick_q && run_q) begin
			phase_q <= phase_q + {{TIME_W{1'b0}}, 1'b1};
		end
	end

	// high for the first half of each period
	// integration gate cuts any period short
	assign ws.wave = ws.enable && ws.integrating && run_q && phase_q < half_len;
endmodule

//--- core/acquisition_strobe_generator.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`include "strobe_map.svh"

module acquisition_strobe_generator
	import strobe_pkg::*;
#(
	parameter int TIME_W = 24
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic trigger_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic one_shot_o,
	output logic periodic_o,
	output logic integrating_o,
	output logic cycle_active_o
);
	localparam logic [TIME_W:0] ONE = {{TIME_W{1'b0}}, 1'b1};

	// software copies
	logic one_shot_en_q;
	logic periodic_en_q;
	trig_mode_e mode_q;
	logic [TIME_W-1:0] one_shot_delay_q;
	logic [TIME_W-1:0] one_shot_width_q;
	logic [TIME_W-1:0] period_q;
	logic [TIME_W-1:0] acq_delay_q;
	logic [TIME_W-1:0] integ_q;
	logic soft_trig_q;

	// per-cycle snapshots
	logic snap_os_en_q;
	logic snap_per_en_q;
	logic snap_level_q;
	logic [TIME_W:0] os_start_q;
	logic [TIME_W:0] os_stop_q;
	logic [TIME_W:0] integ_start_q;
	logic [TIME_W:0] integ_end_q;
	logic [TIME_W-1:0] snap_period_q;

	logic cycle_q;
	logic [TIME_W:0] elapsed_q;
	logic integ_prev_q;
	logic integ_active;
	logic trig_event;
	logic take;
	logic [TIME_W:0] end_sum;
	logic one_shot_d;
	logic [31:0] rdata_d;

	strobe_if #(.TIME_W(TIME_W)) sif ();

	us_tick_gen u_tick (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.tb(sif.timebase)
	);

	periodic_strobe #(.TIME_W(TIME_W)) u_periodic (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.ws(sif.wave_gen)
	);

	// register writes
	// settings are whole microseconds
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			one_shot_en_q <= 1'b0;
			periodic_en_q <= 1'b0;
			mode_q <= MODE_SOFTWARE;
			one_shot_delay_q <= `RST_TIME;
			one_shot_width_q <= `RST_TIME;
			period_q <= `RST_TIME;
			acq_delay_q <= `RST_TIME;
			integ_q <= `RST_TIME;
		end else if (wr_i) begin
			if (addr_i == `REG_CTRL) begin
				one_shot_en_q <= wdata_i[`CTRL_ONE_SHOT_EN];
				periodic_en_q <= wdata_i[`CTRL_PERIODIC_EN];
				mode_q <= trig_mode_e'(wdata_i[`CTRL_MODE_HI:`CTRL_MODE_LO]);
			end else if (addr_i == `REG_ONE_SHOT_DELAY) begin
				one_shot_delay_q <= wdata_i[TIME_W-1:0];
			end else if (addr_i == `REG_ONE_SHOT_WIDTH) begin
				one_shot_width_q <= wdata_i[TIME_W-1:0];
			end else if (addr_i == `REG_PERIOD) begin
				period_q <= wdata_i[TIME_W-1:0];
			end else if (addr_i == `REG_ACQ_DELAY) begin
				acq_delay_q <= wdata_i[TIME_W-1:0];
			end else if (addr_i == `REG_INTEG) begin
				integ_q <= wdata_i[TIME_W-1:0];
			end
		end
	end

	// self-clearing software trigger, only honoured in software mode
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			soft_trig_q <= 1'b0;
		end else begin
			soft_trig_q <= wr_i && addr_i == `REG_CTRL && wdata_i[`CTRL_SOFT_TRIG];
		end
	end

	assign trig_event = (mode_q == MODE_SOFTWARE) ? soft_trig_q : trigger_i;
	// integration ends after acquisition delay plus its own length
	assign end_sum = {1'b0, acq_delay_q} + {1'b0, integ_q};
	// triggers during a running cycle are ignored; zero-length cycles never start
	assign take = trig_event && !cycle_q && integ_q != '0;

	// snapshot settings so mid-cycle writes cannot tear a pulse
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			snap_os_en_q <= 1'b0;
			snap_per_en_q <= 1'b0;
			snap_level_q <= 1'b0;
			os_start_q <= '0;
			os_stop_q <= '0;
			integ_start_q <= '0;
			integ_end_q <= '0;
			snap_period_q <= `RST_TIME;
		end else if (take) begin
			snap_os_en_q <= one_shot_en_q;
			snap_per_en_q <= periodic_en_q;
			snap_level_q <= mode_q == MODE_LEVEL;
			os_start_q <= {1'b0, one_shot_delay_q};
			// stop point is delay plus width
			os_stop_q <= {1'b0, one_shot_delay_q} + {1'b0, one_shot_width_q};
			integ_start_q <= {1'b0, acq_delay_q};
			integ_end_q <= end_sum;
			snap_period_q <= period_q;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			elapsed_q <= '0;
		end else if (take) begin
			elapsed_q <= '0;
		end else if (cycle_q && sif.us_tick) begin
			elapsed_q <= elapsed_q + ONE;
		end
	end

	// cycle spans trigger to end of integration
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cycle_q <= 1'b0;
		end else if (take) begin
			cycle_q <= 1'b1;
		end else if (cycle_q && sif.us_tick && elapsed_q + ONE >= integ_end_q) begin
			cycle_q <= 1'b0;
		end
	end

	// integration window after the acquisition delay
	assign integ_active = cycle_q && elapsed_q >= integ_start_q;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			integ_prev_q <= 1'b0;
		end else begin
			integ_prev_q <= integ_active;
		end
	end

	assign sif.clear = take;
	assign sif.start = integ_active && !integ_prev_q;
	assign sif.integrating = integ_active;
	assign sif.enable = snap_per_en_q;
	assign sif.level_mode = snap_level_q;
	assign sif.period = snap_period_q;
	assign sif.remaining = integ_end_q - elapsed_q;

	// rise at delay, measured from trigger
	// cycle end is integration end, so the pulse is cut there
	always_comb begin
		one_shot_d = snap_os_en_q && cycle_q && elapsed_q >= os_start_q;
		one_shot_d = one_shot_d && elapsed_q < os_stop_q;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			one_shot_o <= 1'b0;
		end else begin
			one_shot_o <= one_shot_d;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			periodic_o <= 1'b0;
		end else begin
			periodic_o <= sif.wave && snap_per_en_q;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			integrating_o <= 1'b0;
			cycle_active_o <= 1'b0;
		end else begin
			integrating_o <= integ_active;
			cycle_active_o <= cycle_q;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (addr_i == `REG_CTRL) begin
			rdata_d[`CTRL_ONE_SHOT_EN] = one_shot_en_q;
			rdata_d[`CTRL_PERIODIC_EN] = periodic_en_q;
			rdata_d[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode_q;
		end else if (addr_i == `REG_ONE_SHOT_DELAY) begin
			rdata_d[TIME_W-1:0] = one_shot_delay_q;
		end else if (addr_i == `REG_ONE_SHOT_WIDTH) begin
			rdata_d[TIME_W-1:0] = one_shot_width_q;
		end else if (addr_i == `REG_PERIOD) begin
			rdata_d[TIME_W-1:0] = period_q;
		end else if (addr_i == `REG_ACQ_DELAY) begin
			rdata_d[TIME_W-1:0] = acq_delay_q;
		end else if (addr_i == `REG_INTEG) begin
			rdata_d[TIME_W-1:0] = integ_q;
		end else if (addr_i == `REG_STATUS) begin
			rdata_d[`STAT_CYCLE] = cycle_active_o;
			rdata_d[`STAT_INTEG] = integrating_o;
			rdata_d[`STAT_ONE_SHOT] = one_shot_o;
			rdata_d[`STAT_PERIODIC] = periodic_o;
		end else if (addr_i == `REG_ELAPSED) begin
			rdata_d[TIME_W:0] = elapsed_q;
		end
	end

	// data only valid the cycle after a read strobe
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			rdata_o <= rdata_d;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end
endmodule

//--- tb/acquisition_strobe_generator_assertions.sv
module strobe_checker (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic one_shot_o,
	input wire logic periodic_o,
	input wire logic integrating_o,
	input wire logic cycle_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_hold8(sig);
		sig[*8];
	endsequence
	sequence s_integ_end;
		$fell(integrating_o);
	endsequence
	property p_os_cyc;
		one_shot_o |-> cycle_active_o;
	endproperty
	a_os_cyc: assert property (p_os_cyc)
		else $error("one-shot outside cycle");
	property p_os_hold;
		$rose(one_shot_o) |-> s_hold8(one_shot_o);
	endproperty
	a_os_hold: assert property (p_os_hold)
		else $error("one-shot too short");
	property p_os_end;
		s_integ_end |-> !one_shot_o;
	endproperty
	a_os_end: assert property (p_os_end)
		else $error("one-shot past integration");
	property p_per_in;
		periodic_o |-> integrating_o;
	endproperty
	a_per_in: assert property (p_per_in)
		else $error("periodic outside integration");
	property p_per_hold;
		$rose(periodic_o) |-> s_hold8(periodic_o);
	endproperty
	a_per_hold: assert property (p_per_hold)
		else $error("periodic half too short");
	property p_per_lag;
		$rose(periodic_o) |-> $past(integrating_o);
	endproperty
	a_per_lag: assert property (p_per_lag)
		else $error("periodic before integration");
	property p_per_end;
		s_integ_end |-> !periodic_o;
	endproperty
	a_per_end: assert property (p_per_end)
		else $error("periodic past integration");
	property p_integ_in;
		integrating_o |-> cycle_active_o;
	endproperty
	a_integ_in: assert property (p_integ_in)
		else $error("integration outside cycle");
	property p_cyc_end;
		$fell(cycle_active_o) |-> s_integ_end;
	endproperty
	a_cyc_end: assert property (p_cyc_end)
		else $error("cycle end without integration end");
endmodule

//--- tb/pulse_meter.sv
module pulse_meter (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic clr_i,
	input wire logic sig_i,
	output int n_o,
	output int len_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int run_q;
	// counted at the fall, so a stuck-high line never counts
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			n_o <= 0;
			len_o <= 0;
			run_q <= 0;
		end else if (clr_i) begin
			n_o <= 0;
			len_o <= 0;
			run_q <= 0;
		end else if (sig_i) begin
			run_q <= run_q + 1;
		end else if (run_q != 0) begin
			len_o <= run_q;
			n_o <= n_o + 1;
			run_q <= 0;
		end
	end
endmodule

//--- tb/acquisition_strobe_generator_tb_top.sv
`include "strobe_map.svh"
module acquisition_strobe_generator_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic trigger_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic clr = 1'b0;
	logic [31:0] rdata_o;
	logic one_shot_o, periodic_o, integrating_o, cycle_active_o;
	int os_n, os_len, per_n, per_len, cyc, c0, n_mismatch, checked;
	acquisition_strobe_generator uut (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.trigger_i(trigger_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .one_shot_o(one_shot_o), .periodic_o(periodic_o),
		.integrating_o(integrating_o), .cycle_active_o(cycle_active_o));
	pulse_meter os_m (.clock_i(clock_i), .rst_b_i(rst_b_i), .clr_i(clr),
		.sig_i(one_shot_o), .n_o(os_n), .len_o(os_len));
	pulse_meter per_m (.clock_i(clock_i), .rst_b_i(rst_b_i), .clr_i(clr),
		.sig_i(periodic_o), .n_o(per_n), .len_o(per_len));
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	// the whole run needs about 2100 cycles
	always @(negedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc > 6000) begin
			n_mismatch++;
			stop_test;
		end
	end
	task stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		chk(rdata_o, e);
	endtask
	function logic sel(input int w);
		case (w)
			0: return one_shot_o;
			1: return integrating_o;
			2: return periodic_o;
			default: return ~cycle_active_o;
		endcase
	endfunction
	task upto(input int w, input logic [31:0] e);
		int n;
		n = 0;
		while (sel(w) !== 1'b1 && n < 1000) begin
			@(negedge clock_i);
			n++;
		end
		chk(cyc - c0, e);
	endtask
	task cfg(input logic [31:0] acq, integ, d, w, p);
		wr(`REG_ACQ_DELAY, acq);
		wr(`REG_INTEG, integ);
		wr(`REG_ONE_SHOT_DELAY, d);
		wr(`REG_ONE_SHOT_WIDTH, w);
		wr(`REG_PERIOD, p);
	endtask
	task go(input logic [31:0] ctrl, input logic pin);
		int n;
		wr(`REG_CTRL, ctrl);
		clr <= 1'b1;
		@(posedge clock_i);
		clr <= 1'b0;
		trigger_i <= pin;
		if (pin) begin
			@(posedge clock_i);
			trigger_i <= 1'b0;
		end
		n = 0;
		while (cycle_active_o !== 1'b1 && n < 9) begin
			@(negedge clock_i);
			n++;
		end
		chk(n, 2);
		c0 = cyc;
	endtask
	task ends(input logic [31:0] on, ol, pn, pl);
		repeat (2) @(negedge clock_i);
		chk(os_n, on);
		chk(os_len, ol);
		chk(per_n, pn);
		chk(per_len, pl);
	endtask
	task s_regs;
		rd(`REG_ONE_SHOT_DELAY, 32'h0);
		wr(`REG_ONE_SHOT_DELAY, 32'hff00_0005);
		rd(`REG_ONE_SHOT_DELAY, 32'h0000_0005);
		rd(8'h20, 32'h0);
	endtask
	task s_soft;
		cfg(2, 5, 1, 2, 2);
		go(32'h13, 1'b0);
		upto(0, 100);
		upto(1, 200);
		upto(2, 201);
		rd(`REG_STATUS, 32'hf);
		upto(3, 700);
		ends(1, 200, 2, 100);
		rd(`REG_CTRL, 32'h3);
	endtask
	task s_edge;
		cfg(1, 3, 2, 5, 1);
		go(32'h07, 1'b1);
		upto(1, 100);
		upto(0, 200);
		@(posedge clock_i);
		trigger_i <= 1'b1;
		@(posedge clock_i);
		trigger_i <= 1'b0;
		upto(3, 400);
		ends(1, 200, 2, 50);
		repeat (5) @(negedge clock_i);
		chk(cycle_active_o, 1'b0);
	endtask
	task s_level;
		cfg(0, 3, 0, 1, 2);
		go(32'h0b, 1'b1);
		upto(0, 0);
		upto(2, 1);
		upto(3, 300);
		ends(1, 100, 2, 99);
	endtask
	task s_off;
		cfg(0, 3, 0, 2, 3);
		go(32'h10, 1'b0);
		upto(3, 300);
		ends(0, 0, 0, 0);
		go(32'h13, 1'b0);
		upto(3, 300);
		ends(1, 200, 0, 0);
	endtask
	initial begin
		repeat (12) @(posedge clock_i);
		rst_b_i <= 1'b1;
		s_regs;
		s_soft;
		s_edge;
		s_level;
		s_off;
		stop_test;
	end
endmodule

bind acquisition_strobe_generator strobe_checker u_chk (.clock_i(clock_i),
	.rst_b_i(rst_b_i), .one_shot_o(one_shot_o), .periodic_o(periodic_o),
	.integrating_o(integrating_o), .cycle_active_o(cycle_active_o));
